/* hw/mix_exec.sv */
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - immediate minus W into W, flags Z, digit carry, C, one cycle
// - rom address is pointer bits 2..0 above W; low byte into W
// - upper six rom bits into table data 5..0, flags kept, two cycles
// - W copied into timer0 mode register in one cycle, flags kept
// - timer0 mode register copied into W, mode and flags kept
// - W xor file register 0..63; dest 0 to W, 1 to file
// - W xor immediate into W, only Z changes, one cycle
module mix_exec (
   input  wire logic                              i_clk_sys,
   input  wire logic                              i_rst_n,
   input  wire logic [2:0]                        i_op,
   input  wire logic                              i_op_valid,
   input  wire logic [7:0]                        i_imm,
   input  wire logic [mix_pkg::MIX_FILE_AW-1:0]   i_file_addr,
   input  wire logic                              i_dest,
   input  wire logic [7:0]                        i_file_rdata,
   input  wire logic [2:0]                        i_tbl_ptr_wdata,
   input  wire logic                              i_tbl_ptr_we,
   input  wire logic [13:0]                       i_rom_rdata,
   output logic      [mix_pkg::MIX_ROM_AW-1:0]    o_rom_addr,
   output logic                                   o_rom_rd,
   output logic      [mix_pkg::MIX_FILE_AW-1:0]   o_file_waddr,
   output logic      [7:0]                        o_file_wdata,
   output logic                                   o_file_we,
   output logic      [7:0]                        o_working_register,
   output logic      [7:0]                        o_timer0_mode_reg,
   output logic      [2:0]                        o_table_high_pointer,
   output logic      [5:0]                        o_table_high_data,
   output logic                                   o_zero_flag,
   output logic                                   o_digit_carry_flag,
   output logic                                   o_carry_flag,
   output logic                                   o_busy
);
   // ==========================================================
   // state
   // one packed record: the comb block fills nxt_r, the clocked block registers it
   typedef struct packed {
      mix_pkg::mix_state_t             st;

      logic [7:0]                      w;
      logic [7:0]                      tmd;
      logic [2:0]                      tptr;
      logic [5:0]                      tdat;
      logic                            z;
      logic                            dc;
      logic                            c;

      logic [mix_pkg::MIX_ROM_AW-1:0]  rom_addr;
      logic                            rom_rd;

      logic [mix_pkg::MIX_FILE_AW-1:0] fwaddr;
      logic [7:0]                      fwdata;
      logic                            fwe;
   } mix_reg_t;

   mix_reg_t r_ff;
   mix_reg_t nxt_r;

   // ==========================================================
   // datapath
   logic [8:0] sub_full;
   logic [4:0] sub_low;
   logic [7:0] xor_file;
   logic [7:0] xor_imm;

   // borrow-free when i >= w, so the ninth bit of i + ~w + 1 is carry
   assign sub_full = {1'b0, i_imm} + {1'b0, ~r_ff.w} + 9'h001;
   // low nibble carry, same inverted-borrow sense as the full carry
   assign sub_low  = {1'b0, i_imm[3:0]} + {1'b0, ~r_ff.w[3:0]} + 5'h01;
   // file operand arrives combinationally in the same cycle as the op
   assign xor_file = r_ff.w ^ i_file_rdata;
   assign xor_imm  = r_ff.w ^ i_imm;

   // ==========================================================
   // decode and result selects
   mix_pkg::mix_op_t                op_dec;
   logic                            op_take;
   logic                            sub_zero;
   logic                            fxor_zero;
   logic                            ixor_zero;
   logic [mix_pkg::MIX_ROM_AW-1:0]  tbl_addr;
   logic [7:0]                      rom_low;
   logic [5:0]                      rom_high;

   // results are formed once here so the case below only steers them
   // codes 0 and 7 decode to no operation
   assign op_dec    = mix_pkg::mix_op_t'(i_op);
   assign op_take   = i_op_valid && (r_ff.st == mix_pkg::MIX_ST_EXEC);
   assign sub_zero  = (sub_full[7:0] == 8'h00);
   assign fxor_zero = (xor_file == 8'h00);
   assign ixor_zero = (xor_imm == 8'h00);
   assign tbl_addr  = {r_ff.tptr, r_ff.w};
   assign rom_low   = i_rom_rdata[7:0];
   assign rom_high  = i_rom_rdata[13:8];

   // ==========================================================
   // next state
   always_comb begin
      // hold by default, so flags an op does not name keep their value
      nxt_r        = r_ff;
      nxt_r.fwe    = 1'b0;
      nxt_r.rom_rd = 1'b0;

      // pointer write runs beside any op; a table read issued now still sees the old pointer
      if (i_tbl_ptr_we) begin
         nxt_r.tptr = i_tbl_ptr_wdata;
      end

      unique case (r_ff.st)
         mix_pkg::MIX_ST_EXEC: begin
            if (op_take) begin
               case (op_dec)
                  mix_pkg::MIX_OP_NONE: begin
                     // idle slot from the decoder: nothing changes
                  end

                  mix_pkg::MIX_OP_SUB_IMM: begin
                     nxt_r.w  = sub_full[7:0];
                     nxt_r.z  = sub_zero;
                     nxt_r.c  = sub_full[8];
                     nxt_r.dc = sub_low[4];
                  end

                  mix_pkg::MIX_OP_TBL_RD: begin
                     nxt_r.rom_addr = tbl_addr;
                     nxt_r.rom_rd   = 1'b1;
                     nxt_r.st       = mix_pkg::MIX_ST_TBL2;
                  end

                  mix_pkg::MIX_OP_LD_TMD: begin
                     nxt_r.tmd = r_ff.w;
                  end

                  mix_pkg::MIX_OP_RD_TMD: begin
                     nxt_r.w = r_ff.tmd;
                  end

                  mix_pkg::MIX_OP_XOR_FILE: begin
                     nxt_r.z = fxor_zero;
                     if (i_dest) begin
                        // write-back is a one-cycle pulse toward the register file
                        nxt_r.fwaddr = i_file_addr;
                        nxt_r.fwdata = xor_file;
                        nxt_r.fwe    = 1'b1;
                     end else begin
                        nxt_r.w = xor_file;
                     end
                  end

                  mix_pkg::MIX_OP_XOR_IMM: begin
                     nxt_r.w = xor_imm;
                     nxt_r.z = ixor_zero;
                  end

                  default: begin
                     // code 7 has no op of its own; like code 0 it changes nothing
                  end
               endcase
            end
         end

         mix_pkg::MIX_ST_TBL2: begin
            // second cycle: rom word is back; ops offered now are refused with no sign
            nxt_r.w    = rom_low;
            nxt_r.tdat = rom_high;
            nxt_r.st   = mix_pkg::MIX_ST_EXEC;
         end

         default: begin
            // a corrupt state code falls back to execute instead of locking up
            nxt_r.st = mix_pkg::MIX_ST_EXEC;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clk_sys) begin
      // synchronous reset: every field to its reset value
      if (!i_rst_n) begin
         r_ff.st       <= mix_pkg::MIX_ST_EXEC;

         r_ff.w        <= mix_pkg::MIX_W_RST;
         r_ff.tmd      <= mix_pkg::MIX_TMD_RST;
         r_ff.tptr     <= mix_pkg::MIX_TPTR_RST;
         r_ff.tdat     <= mix_pkg::MIX_TDAT_RST;
         r_ff.z        <= 1'b0;
         r_ff.dc       <= 1'b0;
         r_ff.c        <= 1'b0;

         r_ff.rom_addr <= '0;
         r_ff.rom_rd   <= 1'b0;
         r_ff.fwaddr   <= '0;
         r_ff.fwdata   <= 8'h00;
         r_ff.fwe      <= 1'b0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign o_rom_addr           = r_ff.rom_addr;
   assign o_rom_rd             = r_ff.rom_rd;

   assign o_file_waddr         = r_ff.fwaddr;
   assign o_file_wdata         = r_ff.fwdata;
   assign o_file_we            = r_ff.fwe;

   assign o_working_register   = r_ff.w;
   assign o_timer0_mode_reg    = r_ff.tmd;
   assign o_table_high_pointer = r_ff.tptr;
   assign o_table_high_data    = r_ff.tdat;

   assign o_zero_flag          = r_ff.z;
   assign o_digit_carry_flag   = r_ff.dc;
   assign o_carry_flag         = r_ff.c;
   // busy is the one-hot bit of the second table cycle
   assign o_busy               = r_ff.st[1];
endmodule

/* hw/mix_pkg.sv */
package mix_pkg;
   // ==========================================================
   // operation codes presented by the core's decoder
   typedef enum logic [2:0] {
      MIX_OP_NONE     = 3'h0,
      MIX_OP_SUB_IMM  = 3'h1,
      MIX_OP_TBL_RD   = 3'h2,
      MIX_OP_LD_TMD   = 3'h3,
      MIX_OP_RD_TMD   = 3'h4,
      MIX_OP_XOR_FILE = 3'h5,
      MIX_OP_XOR_IMM  = 3'h6
   } mix_op_t;

   // ==========================================================
   // states, one-hot
   typedef enum logic [1:0] {
      MIX_ST_EXEC = 2'b01,
      MIX_ST_TBL2 = 2'b10
   } mix_state_t;

   // ==========================================================
   // widths, reset values, cycle counts
   localparam int          MIX_ROM_AW      = 11;
   localparam int          MIX_FILE_AW     = 6;
   localparam logic [7:0]  MIX_W_RST       = 8'h00;
   localparam logic [7:0]  MIX_TMD_RST     = 8'h00;
   localparam logic [5:0]  MIX_TDAT_RST    = 6'h00;
   localparam logic [2:0]  MIX_TPTR_RST    = 3'h0;
   localparam int          MIX_TBL_CYCLES  = 2;
   localparam int          MIX_ONE_CYCLE   = 1;
endpackage

/* sim/mix_exec_monitor.sv */
`timescale 1ns/1ps
module mix_exec_monitor (
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic [2:0]  i_op,
   input wire logic        i_op_valid,
   input wire logic [7:0]  i_imm,
   input wire logic        i_dest,
   input wire logic [7:0]  i_file_rdata,
   input wire logic [13:0] i_rom_rdata,
   input wire logic [10:0] o_rom_addr,
   input wire logic        o_rom_rd,
   input wire logic [7:0]  o_file_wdata,
   input wire logic        o_file_we,
   input wire logic [7:0]  o_working_register,
   input wire logic [7:0]  o_timer0_mode_reg,
   input wire logic [2:0]  o_table_high_pointer,
   input wire logic [5:0]  o_table_high_data,
   input wire logic        o_zero_flag,
   input wire logic        o_digit_carry_flag,
   input wire logic        o_carry_flag,
   input wire logic        o_busy
);
   // ==========================================================
   // taken ops; a busy cycle refuses silently, so it is excluded
   wire tk = i_op_valid & ~o_busy;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_sub_value: assert property (tk && i_op == 3'h1 |=>
      o_working_register == $past(i_imm) - $past(o_working_register)) else $error("sub value");
   a_sub_borrow: assert property (tk && i_op == 3'h1 |=>
      o_carry_flag == ($past(i_imm) >= $past(o_working_register)) && o_digit_carry_flag ==
      ($past(i_imm[3:0]) >= $past(o_working_register[3:0]))) else $error("sub borrow");
   a_tbl_issue: assert property (tk && i_op == 3'h2 |=> o_rom_rd && o_busy &&
      o_rom_addr == {$past(o_table_high_pointer), $past(o_working_register)})
      else $error("table addr");
   a_tbl_load: assert property (o_rom_rd |=> !o_busy &&
      {o_table_high_data, o_working_register} == $past(i_rom_rdata)) else $error("table data");
   a_tmd_load: assert property (tk && i_op == 3'h3 |=>
      o_timer0_mode_reg == $past(o_working_register) && $stable(o_carry_flag))
      else $error("tmode load");
   a_tmd_read: assert property (tk && i_op == 3'h4 |=>
      o_working_register == $past(o_timer0_mode_reg) && $stable(o_timer0_mode_reg))
      else $error("tmode read");
   a_xor_file: assert property (tk && i_op == 3'h5 |=> o_file_we == $past(i_dest) &&
      (o_file_we ? o_file_wdata : o_working_register) == $past(o_working_register ^ i_file_rdata)
      && o_zero_flag == ($past(o_working_register ^ i_file_rdata) == 8'h00)) else $error("fxor");
   a_xor_imm: assert property (tk && i_op == 3'h6 |=>
      o_working_register == $past(o_working_register ^ i_imm) && o_zero_flag ==
      (o_working_register == 8'h00) && $stable(o_carry_flag)) else $error("imm xor");
endmodule
bind mix_exec mix_exec_monitor mix_exec_monitor_inst (.*);

/* sim/mix_mem_model.sv */
`timescale 1ns/1ps
module mix_mem_model (
   input wire logic        i_clk_sys,
   input wire logic [10:0] i_rom_addr,
   input wire logic        i_rom_rd,
   input wire logic [5:0]  i_file_addr,
   input wire logic [5:0]  i_file_waddr,
   input wire logic [7:0]  i_file_wdata,
   input wire logic        i_file_we,
   output logic     [13:0] o_rom_rdata,
   output logic     [7:0]  o_file_rdata
);
   logic [7:0]  regs [64];
   logic [13:0] junk = 14'h2aaa;
   // word is {addr[10:5], ~addr[7:0]}; outside a read it toggles so stale data shows
   assign o_rom_rdata = i_rom_rd ? {i_rom_addr[10:5], ~i_rom_addr[7:0]} : junk;
   assign o_file_rdata = regs[i_file_addr];
   always @(posedge i_clk_sys) begin
      junk <= ~junk;
      if (i_file_we) regs[i_file_waddr] <= i_file_wdata;
   end
   initial for (int k = 0; k < 64; k++) regs[k] = 8'(k * 37);
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_op_valid = 1'b0, i_dest = 1'b0, i_tbl_ptr_we = 1'b0;
   logic [2:0] i_op = 3'h0, i_tbl_ptr_wdata = 3'h0, o_table_high_pointer;
   logic [7:0] i_imm = 8'h00, i_file_rdata, o_file_wdata, o_working_register, o_timer0_mode_reg;
   logic [5:0] i_file_addr = 6'h00, o_file_waddr, o_table_high_data;
   logic [13:0] i_rom_rdata;
   logic [10:0] o_rom_addr;
   logic o_rom_rd, o_file_we, o_zero_flag, o_digit_carry_flag, o_carry_flag, o_busy;
   int error_cnt = 0;
   int num_checks = 0;
   always #25 i_clk_sys = ~i_clk_sys;
   mix_exec mix_exec_inst (.*);
   mix_mem_model mix_mem_model_inst (.i_clk_sys(i_clk_sys), .i_rom_addr(o_rom_addr),
      .i_rom_rd(o_rom_rd), .i_file_addr(i_file_addr), .i_file_waddr(o_file_waddr),
      .i_file_wdata(o_file_wdata), .i_file_we(o_file_we), .o_rom_rdata(i_rom_rdata),
      .o_file_rdata(i_file_rdata));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // ==========================================================
   // one op, then a gap cycle; results are looked at on the falling edge
   task automatic exec(input logic [2:0] c, input logic [7:0] v, input logic d);
      @(posedge i_clk_sys);
      i_op <= c;
      i_imm <= v;
      i_file_addr <= v[5:0];
      i_dest <= d;
      i_op_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_op_valid <= 1'b0;
      @(negedge i_clk_sys);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      exec(3'h6, 8'h06, 1'b0);
      exec(3'h1, 8'h05, 1'b0);
      chk({o_zero_flag, o_digit_carry_flag, o_carry_flag, o_working_register}, 11'h0ff);
      exec(3'h1, 8'hff, 1'b0);
      chk({o_zero_flag, o_digit_carry_flag, o_carry_flag, o_working_register}, 11'h700);
      $display("test sub done");
      exec(3'h6, 8'haa, 1'b0);
      exec(3'h3, 8'h00, 1'b0);
      chk({o_zero_flag, o_digit_carry_flag, o_carry_flag, o_timer0_mode_reg}, 11'h3aa);
      exec(3'h6, 8'haa, 1'b0);
      exec(3'h4, 8'h00, 1'b0);
      chk({o_zero_flag, o_digit_carry_flag, o_carry_flag, o_working_register}, 11'h7aa);
      $display("test tmode done");
      @(posedge i_clk_sys);
      i_tbl_ptr_wdata <= 3'h2;
      i_tbl_ptr_we <= 1'b1;
      @(posedge i_clk_sys);
      i_tbl_ptr_we <= 1'b0;
      exec(3'h6, 8'h9e, 1'b0);
      exec(3'h2, 8'h00, 1'b0);
      chk({o_busy, o_rom_rd, o_rom_addr}, {2'b11, 11'h234});
      @(negedge i_clk_sys);
      chk({o_zero_flag, o_digit_carry_flag, o_carry_flag, o_working_register}, 11'h3cb);
      chk({o_busy, o_table_high_data}, 7'h11);
      $display("test table done");
      exec(3'h5, 8'h3f, 1'b1);
      chk({o_file_we, o_file_waddr, o_file_wdata}, {1'b1, 6'h3f, 8'hd0});
      chk({o_zero_flag, o_working_register}, 9'h0cb);
      exec(3'h5, 8'h3f, 1'b0);
      chk({o_file_we, o_zero_flag, o_working_register}, 10'h01b);
      $display("test file xor done");
      @(posedge i_clk_sys);
      i_op <= 3'h2;
      i_op_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_op <= 3'h6;
      i_imm <= 8'hff;
      @(posedge i_clk_sys);
      i_op_valid <= 1'b0;
      @(negedge i_clk_sys);
      chk({o_busy, o_table_high_data, o_working_register}, {1'b0, 6'h10, 8'he4});
      exec(3'h7, 8'h55, 1'b1);
      exec(3'h0, 8'h55, 1'b1);
      chk({o_file_we, o_zero_flag, o_digit_carry_flag, o_carry_flag, o_working_register}, 12'h3e4);
      $display("test refuse done");
      print_verdict();
   end
endmodule
